// ### qsw_pkg.sv
// Purpose: shared constants for the quad switch fault and shutdown block
// Assumes: 100 MHz pclk, APB with 32-bit data
// Notes: register offsets, field positions and timing counts live here
package qsw_pkg;
    localparam int NCH = 4;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIAG = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // diagnostic word layout, 11 bits
    localparam int DIAG_ERR_LSB = 0;
    localparam int DIAG_CMD_LSB = 4;
    localparam int DIAG_WARN_BIT = 8;
    localparam int DIAG_TSD_BIT = 9;
    localparam int DIAG_OV_BIT = 10;
    localparam int DIAG_W = 11;
    // interrupt status bit positions
    localparam int IRQ_ERR_LSB = 0;
    localparam int IRQ_SHUT_BIT = 4;
    localparam int IRQ_FLAG_BIT = 5;
    localparam int IRQ_W = 6;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;
    // error masking delay
    localparam int MASK_DELAY_US = 75;
    localparam int CLK_MHZ = 100;
    localparam int MASK_CYCLES = MASK_DELAY_US * CLK_MHZ;
    localparam int CNT_W = 14;
endpackage

// ### qsw_sync_if.sv
`timescale 1ns/100ps
// Purpose: bundle of raw and synchronised status levels
// Assumes: one clock domain
// Notes: carries the synchroniser outputs to the main block
interface qsw_sync_if;
    logic [qsw_pkg::NCH-1:0] cmp_raw;
    logic [qsw_pkg::NCH-1:0] cmp_sync;
    logic [2:0] misc_raw;
    logic [2:0] misc_sync;
    modport syncer (input cmp_raw, input misc_raw,
                    output cmp_sync, output misc_sync);
    modport user (output cmp_raw, output misc_raw,
                  input cmp_sync, input misc_sync);
endinterface

// ### qsw_sync2.sv
`timescale 1ns/100ps
// Purpose: two-flop synchroniser for a vector of levels
// Assumes: inputs asynchronous to pclk
// Notes: first stage is read only by the second stage
module qsw_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // double flop to settle metastability
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end
    assign q = sync_ff;
endmodule

// ### qsw_fault_shutdown.sv
`timescale 1ns/100ps
// Purpose: fault detection and shutdown for a four-channel high-side switch
// Assumes: comparator and temperature inputs are asynchronous levels
// Notes: APB slave holds commands, diagnostic word and interrupts
// Function
// - error flag pin is only pulled low or released, never driven high.
// - over-temperature turns all four drivers off and pulls shutdown pin low.
// - outside low on shutdown pin turns every driver off at once.
// - forced shutdown leaves control and diagnostics running, only drivers off.
// - diagnostics do not tell internal from forced shutdown apart.
// - forced shutdown reports per-switch errors plus over-temperature.
// - switch off with output above threshold flags open-load error.
// - switch off with load shorted to supply flags the same error.
// - switch on with output below threshold flags shorted-load error.
// - error flag goes low only after error persists the masking delay.
// - diagnostic word starts with one load-error bit per channel.
// - shutdown bit of diagnostic word reads zero during shutdown.
module qsw_fault_shutdown (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog sense inputs
    input wire logic [3:0] out_above_ref,
    input wire logic over_temp,
    input wire logic temp_warn,
    input wire logic over_volt,
    // thermal shutdown pin, bidirectional active low
    input wire logic tsd_n_in,
    output logic tsd_n_out,
    output logic tsd_n_oe,
    // open-drain general error flag
    output logic err_n_out,
    output logic err_n_oe,
    // switch drivers and interrupt
    output logic [3:0] drive_on,
    output logic irq
);
    // ************************************************
    // input synchronisation
    // ************************************************
    qsw_sync_if sif ();
    logic tsd_pin_sync;

    assign sif.cmp_raw = out_above_ref;
    assign sif.misc_raw = {over_volt, temp_warn, over_temp};

    qsw_sync2 #(.W(qsw_pkg::NCH + 3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({sif.misc_raw, sif.cmp_raw}),
        .q({sif.misc_sync, sif.cmp_sync})
    );

    // pin idles high via pull-up; reset value 0 would fake a shutdown, so
    // a separate inverted synchroniser is used for it
    logic tsd_low_sync;
    qsw_sync2 #(.W(1)) u_sync_tsd (
        .pclk(pclk),
        .presetn(presetn),
        .d(~tsd_n_in),
        .q(tsd_low_sync)
    );
    assign tsd_pin_sync = tsd_low_sync;

    logic ot_s;
    logic warn_s;
    logic ov_s;
    assign ot_s = sif.misc_sync[0];
    assign warn_s = sif.misc_sync[1];
    assign ov_s = sif.misc_sync[2];

    // ************************************************
    // registers
    // ************************************************
    logic [3:0] cmd_ff;
    logic [qsw_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [qsw_pkg::IRQ_W-1:0] irq_mask_ff;
    logic [qsw_pkg::CNT_W-1:0] mask_cnt_ff;
    logic err_flag_ff;
    logic [31:0] prdata_ff;
    logic shut_prev_ff;
    logic flag_prev_ff;
    logic [3:0] load_err_prev_ff;

    logic wr_en;
    logic rd_en;
    logic addr_ok;

    // ************************************************
    // shutdown and fault logic
    // ************************************************
    logic shutdown;
    logic [3:0] load_err;
    logic any_err;
    logic [qsw_pkg::DIAG_W-1:0] diag_word;

    // internal and forced shutdown share one signal, no source kept
    assign shutdown = ot_s | tsd_pin_sync;

    // only drivers are gated; cmd and diagnostics keep running
    assign drive_on = (shutdown | ov_s) ? 4'h0 : cmd_ff;

    // pull the pin low on internal over-temperature; released otherwise
    // so an outside party may pull it
    assign tsd_n_out = 1'b0;
    assign tsd_n_oe = ot_s;

    // per-channel error from commanded state and comparator;
    // off: above ref is open load or short to supply, on: below is short
    always_comb begin
        for (int i = 0; i < qsw_pkg::NCH; i++) begin
            if (cmd_ff[i]) begin
                load_err[i] = ~sif.cmp_sync[i];
            end else begin
                load_err[i] = sif.cmp_sync[i];
            end
        end
    end

    assign any_err = (|load_err) | shutdown | ov_s;

    // diagnostic word, flags active low as on the serial stream
    always_comb begin
        diag_word = '0;
        diag_word[qsw_pkg::DIAG_ERR_LSB +: 4] = ~load_err;
        diag_word[qsw_pkg::DIAG_CMD_LSB +: 4] = cmd_ff;
        diag_word[qsw_pkg::DIAG_WARN_BIT] = ~(warn_s | shutdown);
        diag_word[qsw_pkg::DIAG_TSD_BIT] = ~shutdown;
        diag_word[qsw_pkg::DIAG_OV_BIT] = ~ov_s;
    end

    // masking delay counter: restarts whenever the error clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_cnt_ff <= '0;
        end else if (!any_err) begin
            mask_cnt_ff <= '0;
        end else if (mask_cnt_ff != qsw_pkg::CNT_W'(qsw_pkg::MASK_CYCLES)) begin
            mask_cnt_ff <= mask_cnt_ff + 1'b1;
        end
    end

    // flag asserts after the full delay, releases as soon as errors clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_flag_ff <= 1'b0;
        end else begin
            err_flag_ff <= any_err &&
                (mask_cnt_ff == qsw_pkg::CNT_W'(qsw_pkg::MASK_CYCLES));
        end
    end

    // open drain: low or released, never driven high
    assign err_n_out = 1'b0;
    assign err_n_oe = err_flag_ff;

    // ************************************************
    // apb slave, zero wait state
    // ************************************************
    assign addr_ok = (paddr == qsw_pkg::OFS_CTRL) ||
                     (paddr == qsw_pkg::OFS_DIAG) ||
                     (paddr == qsw_pkg::OFS_IRQ_STAT) ||
                     (paddr == qsw_pkg::OFS_IRQ_MASK) ||
                     (paddr == qsw_pkg::OFS_STATUS);
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign rd_en = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = prdata_ff;

    // switch commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= 4'h0;
        end else if (wr_en && paddr == qsw_pkg::OFS_CTRL) begin
            cmd_ff <= pwdata[3:0];
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_ff <= qsw_pkg::IRQ_MASK_RST;
        end else if (wr_en && paddr == qsw_pkg::OFS_IRQ_MASK) begin
            irq_mask_ff <= pwdata[qsw_pkg::IRQ_W-1:0];
        end
    end

    // edge history for event detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shut_prev_ff <= 1'b0;
            flag_prev_ff <= 1'b0;
            load_err_prev_ff <= 4'h0;
        end else begin
            shut_prev_ff <= shutdown;
            flag_prev_ff <= err_flag_ff;
            load_err_prev_ff <= load_err;
        end
    end

    // sticky status: rising edges set, write one clears, set wins
    logic [qsw_pkg::IRQ_W-1:0] irq_set;
    logic [qsw_pkg::IRQ_W-1:0] irq_clr;
    always_comb begin
        irq_set = '0;
        irq_set[qsw_pkg::IRQ_ERR_LSB +: 4] = load_err & ~load_err_prev_ff;
        irq_set[qsw_pkg::IRQ_SHUT_BIT] = shutdown & ~shut_prev_ff;
        irq_set[qsw_pkg::IRQ_FLAG_BIT] = err_flag_ff & ~flag_prev_ff;
        irq_clr = '0;
        if (wr_en && paddr == qsw_pkg::OFS_IRQ_STAT) begin
            irq_clr = pwdata[qsw_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= '0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // read data captured in setup so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (rd_en) begin
            unique case (paddr)
                qsw_pkg::OFS_CTRL: prdata_ff <= {28'h0, cmd_ff};
                qsw_pkg::OFS_DIAG: prdata_ff <= {21'h0, diag_word};
                qsw_pkg::OFS_IRQ_STAT: prdata_ff <= {26'h0, irq_stat_ff};
                qsw_pkg::OFS_IRQ_MASK: prdata_ff <= {26'h0, irq_mask_ff};
                qsw_pkg::OFS_STATUS: prdata_ff <= {24'h0, err_flag_ff,
                    tsd_pin_sync, ot_s, shutdown, drive_on};
                default: prdata_ff <= '0;
            endcase
        end
    end
endmodule

// ### qsw_fs_checker_assertions.sv
// Purpose: port checks for the fault and shutdown block
// Assumes: one pclk domain, presetn async active low
// Notes: run counter mirrors raw faults seen at the pins
`timescale 1ns/100ps
module qsw_fs_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // sense inputs and pins
    input wire logic [3:0] out_above_ref,
    input wire logic over_temp,
    input wire logic over_volt,
    input wire logic tsd_n_in,
    input wire logic tsd_n_out,
    input wire logic tsd_n_oe,
    input wire logic err_n_out,
    input wire logic err_n_oe,
    input wire logic [3:0] drive_on
);
    localparam int RUN_MIN = qsw_pkg::MASK_CYCLES;
    int run_cnt;
    logic raw_err;
    // loads judged against the driven state, so shutdown counts by itself
    assign raw_err = over_temp | ~tsd_n_in | over_volt
                     | (|(drive_on ^ out_above_ref));
    // consecutive fault cycles, saturating to avoid wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cnt <= 0;
        end else begin
            run_cnt <= !raw_err ? 0 : (run_cnt > 9999 ? run_cnt : run_cnt + 1);
        end
    end
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    err_low_only_a: assert property (!err_n_out && !tsd_n_out)
        else $error("pin driven high");
    hot_off_a: assert property (over_temp[*3] |-> !drive_on && tsd_n_oe)
        else $error("hot but drivers on");
    hot_clear_a: assert property (!over_temp[*3] |-> !tsd_n_oe)
        else $error("shutdown pull stuck");
    pin_off_a: assert property (!tsd_n_in[*3] |-> drive_on == 4'h0)
        else $error("forced but drivers on");
    bus_alive_a: assert property (psel && penable |-> pready)
        else $error("bus stalled");
    flag_delay_a: assert property ($rose(err_n_oe) |-> run_cnt >= RUN_MIN)
        else $error("flag too early");
    flag_release_a: assert property (!raw_err[*5] |-> !err_n_oe)
        else $error("flag held");
    sync_lag_a: assert property ($rose(over_temp) && !tsd_n_oe |=> !tsd_n_oe)
        else $error("unsynchronised path");
endmodule
bind qsw_fault_shutdown qsw_fs_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready),
    .out_above_ref(out_above_ref), .over_temp(over_temp),
    .over_volt(over_volt), .tsd_n_in(tsd_n_in), .tsd_n_out(tsd_n_out),
    .tsd_n_oe(tsd_n_oe), .err_n_out(err_n_out), .err_n_oe(err_n_oe),
    .drive_on(drive_on));

// ### qsw_failsafe_ctrl.sv
// Purpose: outside fail-safe controller on the two shared lines
// Assumes: both lines have pull-ups
// Notes: pulls shutdown low on request, watches the error line
`timescale 1ns/100ps
module qsw_failsafe_ctrl (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request and shared lines
    input wire logic force_req,
    input wire logic err_pin,
    output logic pull_low,
    output logic fault_seen
);
    // only ever pulls low: holding high would defeat thermal protection
    assign pull_low = force_req;
    // wired error line, low means some package has a fault
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_seen <= 1'b0;
        end else begin
            fault_seen <= ~err_pin;
        end
    end
endmodule

// ### tb_quad_switch_fault_shutdown.sv
// Purpose: self-checking bench for the fault and shutdown block
// Assumes: zero wait state bus, 100 MHz pclk
// Notes: full masking delay is run, about 15k cycles
`timescale 1ns/100ps
module tb_quad_switch_fault_shutdown;
    logic pclk, presetn, psel, penable, pwrite, over_temp, temp_warn;
    logic over_volt, pready, pslverr, tsd_n_out, tsd_n_oe, err_n_out, slv;
    logic err_n_oe, irq, force_req, pull_low, fault_seen, tsd_pin, err_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] out_above_ref, drive_on;
    int fail_count, checked, cmd, cmp, warn;
    // pulled-up wired lines
    assign tsd_pin = ~(tsd_n_oe | pull_low);
    assign err_pin = ~err_n_oe;
    qsw_fault_shutdown u_qsw_fault_shutdown (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .out_above_ref(out_above_ref), .over_temp(over_temp),
        .temp_warn(temp_warn), .over_volt(over_volt), .tsd_n_in(tsd_pin),
        .tsd_n_out(tsd_n_out), .tsd_n_oe(tsd_n_oe), .err_n_out(err_n_out),
        .err_n_oe(err_n_oe), .drive_on(drive_on), .irq(irq));
    qsw_failsafe_ctrl u_qsw_failsafe_ctrl (.pclk(pclk), .presetn(presetn),
        .force_req(force_req), .err_pin(err_pin), .pull_low(pull_low),
        .fault_seen(fault_seen));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one setup and one access phase; waits for pready, bench timeout only
    task automatic apb(input logic wr, input logic [7:0] a, input int d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // diagnostic word: error bits active low, then commands and status
    function automatic int diag_exp(int c, int p, int sh, int ov, int w);
        return (~(c ^ p) & 15) | (c << 4) | ((w | sh) ? 0 : 256)
               | (sh ? 0 : 512) | (ov ? 0 : 1024);
    endfunction
    task automatic test_done();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // watchdog, well past the expected 15k cycles
    initial begin
        #400000;
        fail_count++;
        test_done();
    end
    initial begin
        {presetn, psel, penable, pwrite, over_temp, temp_warn} = '0;
        {over_volt, force_req, paddr, pwdata, out_above_ref} = '0;
        void'($urandom(32'hcfc7));
        tick(6);
        presetn <= 1'b1;
        apb(0, qsw_pkg::OFS_IRQ_MASK, 0);
        chk("mask reset", rd, qsw_pkg::IRQ_MASK_RST);
        apb(0, 8'h20, 0);
        chk("unmapped err", {31'h0, slv}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            cmd = $urandom & 15;
            cmp = $urandom & 15;
            warn = $urandom & 1;
            apb(1, qsw_pkg::OFS_CTRL, cmd);
            out_above_ref <= cmp[3:0];
            temp_warn <= warn[0];
            tick(4);
            apb(0, qsw_pkg::OFS_DIAG, 0);
            chk("diag", rd, diag_exp(cmd, cmp, 0, 0, warn));
            chk("drive", drive_on, cmd[3:0]);
        end
        temp_warn <= 1'b0;
        out_above_ref <= 4'h0;
        // hot, forced from outside, overvoltage
        for (int m = 0; m < 3; m++) begin
            {over_temp, force_req, over_volt} <= 3'b100 >> m;
            apb(1, qsw_pkg::OFS_CTRL, 5);
            tick(3);
            chk("drive off", drive_on, 0);
            chk("tsd pull", tsd_n_oe, m == 0);
            apb(0, qsw_pkg::OFS_DIAG, 0);
            chk("diag shut", rd, diag_exp(5, 0, m < 2, m == 2, 0));
            // status: drivers off, shutdown, hot, pin low, flag still quiet
            apb(0, qsw_pkg::OFS_STATUS, 0);
            chk("status shut", rd, ((m < 2) ? 16 : 0) | ((m == 0) ? 32 : 0)
                | ((m < 2) ? 64 : 0));
        end
        {over_temp, force_req, over_volt} <= 3'b000;
        out_above_ref <= 4'h5;
        tick(4);
        chk("drive back", drive_on, 5);
        apb(1, qsw_pkg::OFS_IRQ_STAT, 32'h3f);
        apb(1, qsw_pkg::OFS_IRQ_MASK, 32'h20);
        tick(1);
        chk("irq idle", irq, 0);
        out_above_ref <= 4'h4;
        tick(7400);
        out_above_ref <= 4'h5;
        tick(6);
        chk("flag short", err_n_oe, 0);
        out_above_ref <= 4'h4;
        tick(7520);
        chk("flag long", {err_n_oe, fault_seen, irq}, 3'b111);
        apb(0, qsw_pkg::OFS_IRQ_STAT, 0);
        chk("irq stat", rd, 32'h21);
        apb(1, qsw_pkg::OFS_IRQ_MASK, 0);
        out_above_ref <= 4'h5;
        tick(4);
        chk("masked", {irq, err_n_oe}, 2'b00);
        apb(1, qsw_pkg::OFS_IRQ_STAT, 32'h21);
        apb(0, qsw_pkg::OFS_IRQ_STAT, 0);
        chk("stat clear", rd, 0);
        test_done();
    end
endmodule
